// File: serial_out_consts.svh
// Constants for the framed serial output port
// Functional notes
// - Frame-end output is high during the last serial clock cycle of the slot.
// - Frame-end rises on the rising edge that shifts out the last bit.
// - Cascaded device samples frame-end on falling edge, starts next edge.
// - Word length code 00=16, 01=24, 10=32 bits, 11 disallowed.
// - Words go MSB first, left justified, fill bits at the end.
// - With 24 or 32 bit words, I and Q carry 23 bits.
// - Single-channel mode without append: A I word then A Q word.
// - Diversity mode: four words, A I, A Q, B I, B Q.
// - Append high adds one read-data word, zero when no read occurred.
// - A pending register read is appended whatever the append input says.
// - Master clock is processing clock / 2, or / (2*D) for D nonzero.
// - In cascade mode the divider is ignored and the external clock used.
// - Generated serial clock never exceeds half the processing clock.
// - Master select high drives clock and frame sync; low accepts them.
// - Command input and frame sync sampled on falling, outputs change rising.
// - Master frame sync pulses one cycle; a sampled sync starts a full slot.
// - Data output is high impedance outside the device's own slot.
`ifndef SERIAL_OUT_CONSTS_SVH
`define SERIAL_OUT_CONSTS_SVH
`define WL_SEL_16       2'b00
`define WL_SEL_24       2'b01
`define WL_SEL_32       2'b10
`define WORD_BITS_16    6'd16
`define WORD_BITS_24    6'd24
`define WORD_BITS_32    6'd32
`define SAMPLE_RES_16   6'd16
`define SAMPLE_RES_23   6'd23
`define READ_BITS       6'd16
`define WORDS_SINGLE    3'd2
`define WORDS_DIVERSITY 3'd4
`define DIV_ZERO        4'h0
`define DIV_MIN_HALF    4'h1
`endif

// File: serial_out_pkg.sv
// Types shared by the serial output port modules
package serial_out_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SYNC  = 3'b010,
		ST_SHIFT = 3'b100
	} frame_state_t;
	typedef logic [1:0]  wl_sel_t;
	typedef logic [23:0] sample_t;
	typedef logic [15:0] read_word_t;
	typedef logic [31:0] serial_word_t;
endpackage

// File: sclk_evt_if.sv
// Serial clock level and edge pulses between port modules
`timescale 1ns/1ps
interface sclk_evt_if;
	logic level;
	logic rise;
	logic fall;
	modport src (output level, output rise, output fall);
	modport dst (input level, input rise, input fall);
endinterface // sclk_evt_if

// File: sclk_divider.sv
// Serial clock generator for bus master operation
`timescale 1ns/1ps
`include "serial_out_consts.svh"
module sclk_divider
(
	input  wire logic         clock_i,
	input  wire logic         rst_b_i,
	input  wire logic         enable_i,
	input  wire logic [3:0]   serial_clock_divider_i,
	sclk_evt_if.src           evt
);
	logic [3:0] cnt_reg;
	logic [3:0] half_next;

	// Half period in processing cycles, never below one
	assign half_next = (serial_clock_divider_i == `DIV_ZERO) ?
		`DIV_MIN_HALF : serial_clock_divider_i;

	// Toggle the serial clock every half period
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i || !enable_i)
		begin
			cnt_reg   <= 4'h0;
			evt.level <= 1'b0;
			evt.rise  <= 1'b0;
			evt.fall  <= 1'b0;
		end
		else if (cnt_reg >= half_next - 4'h1)
		begin
			cnt_reg   <= 4'h0;
			evt.level <= ~evt.level;
			evt.rise  <= ~evt.level;
			evt.fall  <= evt.level;
		end
		else
		begin
			cnt_reg  <= cnt_reg + 4'h1;
			evt.rise <= 1'b0;
			evt.fall <= 1'b0;
		end
	end

	property p_no_back_rise;
		@(posedge clock_i) disable iff (!rst_b_i)
		evt.rise |=> !evt.rise;
	endproperty
	a_no_back_rise: assert property (p_no_back_rise)
		else $error("serial clock above half processing clock");

	property p_div_half;
		@(posedge clock_i) disable iff (!rst_b_i)
		(enable_i && serial_clock_divider_i == 4'h2
			&& $stable(serial_clock_divider_i) && evt.rise)
			##1 (enable_i && serial_clock_divider_i == 4'h2)
			|-> !evt.fall ##1 evt.fall;
	endproperty
	a_div_half: assert property (p_div_half)
		else $error("divider two gives wrong half period");
endmodule // sclk_divider

// File: pin_sync.sv
// Two-stage synchronisers for the port's pin inputs
`timescale 1ns/1ps
module pin_sync
(
	input  wire logic clock_i,
	input  wire logic rst_b_i,
	input  wire logic sclk_pin_i,
	input  wire logic fs_pin_i,
	input  wire logic cmd_pin_i,
	input  wire logic master_pin_i,
	output logic      fs_sync_o,
	output logic      cmd_sync_o,
	output logic      master_sync_o,
	sclk_evt_if.src   evt
);
	logic [3:0] pins;
	logic [3:0] stage1_reg;
	logic [3:0] stage2_reg;
	logic       sclk_last_reg;

	assign pins = {master_pin_i, cmd_pin_i, fs_pin_i, sclk_pin_i};

	// One two-flop chain per pin
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_sync
			always_ff @(posedge clock_i)
			begin
				if (!rst_b_i)
				begin
					stage1_reg[g] <= 1'b0;
					stage2_reg[g] <= 1'b0;
				end
				else
				begin
					stage1_reg[g] <= pins[g];
					stage2_reg[g] <= stage1_reg[g];
				end
			end
		end
	endgenerate

	// Edge detect on the synchronised serial clock
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
			sclk_last_reg <= 1'b0;
		else
			sclk_last_reg <= stage2_reg[0];
	end

	assign evt.level     = stage2_reg[0];
	assign evt.rise      = stage2_reg[0] & ~sclk_last_reg;
	assign evt.fall      = ~stage2_reg[0] & sclk_last_reg;
	assign fs_sync_o     = stage2_reg[1];
	assign cmd_sync_o    = stage2_reg[2];
	assign master_sync_o = stage2_reg[3];
endmodule // pin_sync

// File: serial_output_port.sv
// Framed serial output port: framing, shifting, clock and sync control
`timescale 1ns/1ps
`include "serial_out_consts.svh"
module serial_output_port
(
	input  wire logic                   clock_i,
	input  wire logic                   rst_b_i,
	input  wire logic                   bus_master_sel_i,
	input  wire logic [3:0]             serial_clock_divider_i,
	input  wire serial_out_pkg::wl_sel_t word_length_sel_i,
	input  wire logic                   append_i,
	input  wire logic                   diversity_mode_i,
	input  wire logic                   sample_valid_i,
	input  wire serial_out_pkg::sample_t a_i_i,
	input  wire serial_out_pkg::sample_t a_q_i,
	input  wire serial_out_pkg::sample_t b_i_i,
	input  wire serial_out_pkg::sample_t b_q_i,
	input  wire logic                   read_req_i,
	input  wire serial_out_pkg::read_word_t read_data_i,
	input  wire logic                   sclk_i,
	output logic                        sclk_o,
	output logic                        sclk_oe_o,
	input  wire logic                   frame_sync_i,
	output logic                        frame_sync_o,
	output logic                        frame_sync_oe_o,
	input  wire logic                   serial_cmd_in_i,
	output logic                        cmd_bit_o,
	output logic                        cmd_strobe_o,
	output logic                        serial_data_out_o,
	output logic                        serial_data_oe_o,
	output logic                        frame_end_out_o
);
	import serial_out_pkg::*;

	sclk_evt_if dv_evt ();
	sclk_evt_if pin_evt ();

	logic         master;
	logic         fs_sync;
	logic         cmd_sync;
	logic         rise;
	logic         fall;
	logic         start;
	frame_state_t state_reg;
	logic         fs_out_reg;
	logic         fs_seen_reg;
	logic         data_ready_reg;
	logic         read_pending_reg;
	read_word_t   read_data_reg;
	sample_t      shadow_reg [0:3];
	sample_t      sample_in  [0:3];
	serial_word_t word_src   [0:4];
	serial_word_t frame_word_reg [0:4];
	serial_word_t append_word;
	logic         append_now;
	logic [2:0]   nwords_base;
	logic [2:0]   nwords_reg;
	logic [5:0]   wl_len;
	logic [5:0]   wl_len_reg;
	logic [5:0]   samp_res_reg;
	logic [5:0]   bit_reg;
	logic [2:0]   word_reg;
	logic         last_out_reg;
	logic [5:0]   bit_next;
	logic [2:0]   word_next;
	logic         last_next;
	logic [4:0]   bit_pos;
	logic [5:0]   valid_len;

	// Master generates its own clock, cascade follows the pin
	sclk_divider i_sclk_divider
	(
		.clock_i                (clock_i),
		.rst_b_i                (rst_b_i),
		.enable_i               (master),
		.serial_clock_divider_i (serial_clock_divider_i),
		.evt                    (dv_evt)
	);

	pin_sync i_pin_sync
	(
		.clock_i       (clock_i),
		.rst_b_i       (rst_b_i),
		.sclk_pin_i    (sclk_i),
		.fs_pin_i      (frame_sync_i),
		.cmd_pin_i     (serial_cmd_in_i),
		.master_pin_i  (bus_master_sel_i),
		.fs_sync_o     (fs_sync),
		.cmd_sync_o    (cmd_sync),
		.master_sync_o (master),
		.evt           (pin_evt)
	);

	// Edge source chosen by master select
	assign rise  = master ? dv_evt.rise : pin_evt.rise;
	assign fall  = master ? dv_evt.fall : pin_evt.fall;
	assign start = rise && fs_seen_reg;

	// Clock and sync pin drive, only as master
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			sclk_o          <= 1'b0;
			sclk_oe_o       <= 1'b0;
			frame_sync_o    <= 1'b0;
			frame_sync_oe_o <= 1'b0;
		end
		else
		begin
			sclk_o          <= master & dv_evt.level;
			sclk_oe_o       <= master;
			frame_sync_o    <= fs_out_reg;
			frame_sync_oe_o <= master;
		end
	end

	// Falling-edge sampling of sync and command input
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			fs_seen_reg  <= 1'b0;
			cmd_bit_o    <= 1'b0;
			cmd_strobe_o <= 1'b0;
		end
		else
		begin
			cmd_strobe_o <= fall;
			if (fall)
			begin
				fs_seen_reg <= master ? fs_out_reg : fs_sync;
				cmd_bit_o   <= cmd_sync;
			end
			else if (rise)
				fs_seen_reg <= 1'b0;
		end
	end

	// Latch new samples per channel
	assign sample_in[0] = a_i_i;
	assign sample_in[1] = a_q_i;
	assign sample_in[2] = b_i_i;
	assign sample_in[3] = b_q_i;
	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : g_shadow
			always_ff @(posedge clock_i)
			begin
				if (!rst_b_i)
					shadow_reg[g] <= 24'h000000;
				else if (sample_valid_i)
					shadow_reg[g] <= sample_in[g];
			end
			// Left justified, fill bits zero
			assign word_src[g] = (word_length_sel_i == `WL_SEL_16) ?
				{shadow_reg[g][23:8], 16'h0000} :
				{shadow_reg[g][23:1], 9'h000};
		end
	endgenerate

	// Read word slot and frame length
	assign append_now  = append_i || read_pending_reg;
	assign append_word = read_pending_reg ?
		{read_data_reg, 16'h0000} : 32'h00000000;
	assign word_src[4] = append_word;
	assign nwords_base = diversity_mode_i ?
		`WORDS_DIVERSITY : `WORDS_SINGLE;

	// Word length decode, code 11 falls back to 16
	always_comb
	begin
		unique case (word_length_sel_i)
			`WL_SEL_24: wl_len = `WORD_BITS_24;
			`WL_SEL_32: wl_len = `WORD_BITS_32;
			default:    wl_len = `WORD_BITS_16;
		endcase
	end

	// Data-ready and pending read flags, set beats clear
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			data_ready_reg   <= 1'b0;
			read_pending_reg <= 1'b0;
			read_data_reg    <= 16'h0000;
		end
		else
		begin
			if (sample_valid_i)
				data_ready_reg <= 1'b1;
			else if (rise && state_reg == ST_IDLE && master && !start)
				data_ready_reg <= 1'b0;
			if (read_req_i)
			begin
				read_pending_reg <= 1'b1;
				read_data_reg    <= read_data_i;
			end
			else if (start)
				read_pending_reg <= 1'b0;
		end
	end

	// Next shift position
	always_comb
	begin
		if (bit_reg == wl_len_reg - 6'd1)
		begin
			bit_next  = 6'd0;
			word_next = word_reg + 3'd1;
		end
		else
		begin
			bit_next  = bit_reg + 6'd1;
			word_next = word_reg;
		end
		last_next = (word_next == nwords_reg - 3'd1) &&
			(bit_next == wl_len_reg - 6'd1);
		bit_pos   = 5'(6'd31 - bit_next);
	end

	// Frame state machine and shifter
	always_ff @(posedge clock_i)
	begin
		if (!rst_b_i)
		begin
			state_reg         <= ST_IDLE;
			fs_out_reg        <= 1'b0;
			bit_reg           <= 6'd0;
			word_reg          <= 3'd0;
			last_out_reg      <= 1'b0;
			nwords_reg        <= `WORDS_SINGLE;
			wl_len_reg        <= `WORD_BITS_16;
			samp_res_reg      <= `SAMPLE_RES_16;
			serial_data_out_o <= 1'b0;
			serial_data_oe_o  <= 1'b0;
			frame_end_out_o   <= 1'b0;
			for (int i = 0; i < 5; i++)
				frame_word_reg[i] <= 32'h00000000;
		end
		else if (start)
		begin
			// Slot starts from here; a later sampled sync restarts it
			state_reg    <= ST_SHIFT;
			fs_out_reg   <= 1'b0;
			for (int i = 0; i < 5; i++)
				frame_word_reg[i] <= word_src[i];
			if (!diversity_mode_i)
				frame_word_reg[2] <= append_word;
			nwords_reg   <= nwords_base + {2'b00, append_now};
			wl_len_reg   <= wl_len;
			samp_res_reg <= (wl_len == `WORD_BITS_16) ?
				`SAMPLE_RES_16 : `SAMPLE_RES_23;
			bit_reg      <= 6'd0;
			word_reg     <= 3'd0;
			last_out_reg <= 1'b0;
			serial_data_out_o <= word_src[0][31];
			serial_data_oe_o  <= 1'b1;
			frame_end_out_o   <= 1'b0;
		end
		else if (rise)
		begin
			unique case (state_reg)
				ST_IDLE:
					if (master && data_ready_reg)
					begin
						fs_out_reg <= 1'b1;
						state_reg  <= ST_SYNC;
					end
				ST_SYNC:
				begin
					fs_out_reg <= 1'b0;
					state_reg  <= ST_IDLE;
				end
				ST_SHIFT:
					if (last_out_reg)
					begin
						state_reg         <= ST_IDLE;
						serial_data_out_o <= 1'b0;
						serial_data_oe_o  <= 1'b0;
						frame_end_out_o   <= 1'b0;
					end
					else
					begin
						bit_reg      <= bit_next;
						word_reg     <= word_next;
						last_out_reg <= last_next;
						serial_data_out_o <=
							frame_word_reg[word_next][bit_pos];
						frame_end_out_o <= last_next;
					end
			endcase
		end
	end

	// Valid bit count of the word now on the pin
	assign valid_len = (word_reg < nwords_base) ? samp_res_reg : `READ_BITS;

	property p_fe_in_slot;
		@(posedge clock_i) disable iff (!rst_b_i)
		frame_end_out_o |-> serial_data_oe_o && last_out_reg;
	endproperty
	a_fe_in_slot: assert property (p_fe_in_slot)
		else $error("frame end outside last bit");

	property p_fe_drops;
		@(posedge clock_i) disable iff (!rst_b_i)
		(frame_end_out_o && rise && !start) |=> !frame_end_out_o;
	endproperty
	a_fe_drops: assert property (p_fe_drops)
		else $error("frame end longer than one serial cycle");

	property p_fe_on_rise;
		@(posedge clock_i) disable iff (!rst_b_i)
		$rose(frame_end_out_o) |-> $past(rise) && last_out_reg;
	endproperty
	a_fe_on_rise: assert property (p_fe_on_rise)
		else $error("frame end not raised with last bit");

	property p_idle_hiz;
		@(posedge clock_i) disable iff (!rst_b_i)
		(state_reg != ST_SHIFT) |-> !serial_data_oe_o;
	endproperty
	a_idle_hiz: assert property (p_idle_hiz)
		else $error("data driven outside slot");

	property p_slave_pins;
		@(posedge clock_i) disable iff (!rst_b_i)
		!master |=> !sclk_oe_o && !frame_sync_oe_o;
	endproperty
	a_slave_pins: assert property (p_slave_pins)
		else $error("cascade mode drives clock or sync");

	property p_fs_one_cycle;
		@(posedge clock_i) disable iff (!rst_b_i)
		(fs_out_reg && rise) |=> !fs_out_reg;
	endproperty
	a_fs_one_cycle: assert property (p_fs_one_cycle)
		else $error("frame sync held past one serial cycle");

	property p_fill_zero;
		@(posedge clock_i) disable iff (!rst_b_i)
		(state_reg == ST_SHIFT && serial_data_oe_o && bit_reg >= valid_len)
			|-> !serial_data_out_o;
	endproperty
	a_fill_zero: assert property (p_fill_zero)
		else $error("fill bit not zero");

	property p_frame_len;
		@(posedge clock_i) disable iff (!rst_b_i)
		start |=> nwords_reg == nwords_base + {2'b00, $past(append_now)};
	endproperty
	a_frame_len: assert property (p_frame_len)
		else $error("wrong words per frame");
endmodule // serial_output_port

// File: ser_partner.sv
// Far-side model: serial receiver and cascade clock and sync source
`timescale 1ns/1ps
module ser_partner
#(
	parameter int HALF = 8
)
(
	input  wire logic         clock_i,
	input  wire logic         master_i,
	input  wire logic         clr_i,
	input  wire logic         start_i,
	input  wire logic [7:0]   ncyc_i,
	input  wire logic         sclk_pin_i,
	input  wire logic         fs_pin_i,
	input  wire logic         data_i,
	input  wire logic         oe_i,
	input  wire logic         fe_i,
	output logic              ext_sclk_o,
	output logic              ext_fs_o,
	output logic [159:0]      cap_o,
	output logic [7:0]        nbits_o,
	output logic [7:0]        fe_cnt_o,
	output logic [7:0]        fe_pos_o,
	output logic [7:0]        fs_cnt_o
);
	logic sclk;
	logic prev;
	logic line;

	// Weak pull-down holds the shared line low when released
	assign line = oe_i ? data_i : 1'b0;
	assign sclk = master_i ? sclk_pin_i : ext_sclk_o;

	initial
	begin
		ext_sclk_o = 1'b0;
		ext_fs_o = 1'b0;
		prev = 1'b0;
	end

	// Capture bits, frame end and sync level on falling serial edges
	always @(negedge clock_i)
	begin
		prev <= sclk;
		if (clr_i)
		begin
			cap_o <= '0;
			nbits_o <= 8'h00;
			fe_cnt_o <= 8'h00;
			fe_pos_o <= 8'h00;
			fs_cnt_o <= 8'h00;
		end
		else if (prev && !sclk)
		begin
			if (oe_i)
			begin
				cap_o <= {cap_o[158:0], line};
				nbits_o <= nbits_o + 8'h01;
			end
			if (fe_i)
			begin
				fe_cnt_o <= fe_cnt_o + 8'h01;
				fe_pos_o <= nbits_o + 8'h01;
			end
			if (master_i && fs_pin_i)
				fs_cnt_o <= fs_cnt_o + 8'h01;
		end
	end

	// One serial clock cycle, rising first
	task automatic cyc();
		ext_sclk_o <= 1'b1;
		repeat (HALF) @(posedge clock_i);
		ext_sclk_o <= 1'b0;
		repeat (HALF) @(posedge clock_i);
	endtask

	// Cascade source: one-cycle sync, then clock only within the frame
	always
	begin
		@(posedge clock_i);
		if (start_i)
		begin
			ext_fs_o <= 1'b1;
			cyc();
			ext_fs_o <= 1'b0;
			repeat (ncyc_i) cyc();
		end
	end
endmodule // ser_partner

// File: serial_output_port_tb.sv
// Self-checking testbench for the framed serial output port
`timescale 1ns/1ps
module serial_output_port_tb;
	import serial_out_pkg::*;
	logic         clock_i, rst_b_i, bus_master_sel_i, append_i;
	logic         diversity_mode_i, sample_valid_i, read_req_i;
	logic         serial_cmd_in_i, clr, start;
	logic [3:0]   serial_clock_divider_i;
	wl_sel_t      word_length_sel_i;
	sample_t      a_i_i, a_q_i, b_i_i, b_q_i;
	read_word_t   read_data_i;
	logic         sclk_o, sclk_oe_o, frame_sync_o, frame_sync_oe_o;
	logic         cmd_bit_o, cmd_strobe_o, serial_data_out_o;
	logic         serial_data_oe_o, frame_end_out_o, ext_sclk, ext_fs;
	wire          sclk_i, frame_sync_i;
	logic [7:0]   ncyc, nbits, fe_cnt, fe_pos, fs_cnt;
	logic [159:0] cap;
	int           err_total = 0;
	int           tests_run = 0;

	// Pin levels from whichever party drives them
	assign sclk_i = (sclk_oe_o === 1'b1) ? sclk_o : ext_sclk;
	assign frame_sync_i = (frame_sync_oe_o === 1'b1) ? frame_sync_o : ext_fs;

	serial_output_port i_serial_output_port (.clock_i, .rst_b_i,
		.bus_master_sel_i, .serial_clock_divider_i, .word_length_sel_i,
		.append_i, .diversity_mode_i, .sample_valid_i, .a_i_i, .a_q_i,
		.b_i_i, .b_q_i, .read_req_i, .read_data_i, .sclk_i, .sclk_o,
		.sclk_oe_o, .frame_sync_i, .frame_sync_o, .frame_sync_oe_o,
		.serial_cmd_in_i, .cmd_bit_o, .cmd_strobe_o, .serial_data_out_o,
		.serial_data_oe_o, .frame_end_out_o);

	ser_partner i_ser_partner (.clock_i, .master_i(bus_master_sel_i),
		.clr_i(clr), .start_i(start), .ncyc_i(ncyc), .sclk_pin_i(sclk_o),
		.fs_pin_i(frame_sync_o), .data_i(serial_data_out_o),
		.oe_i(serial_data_oe_o), .fe_i(frame_end_out_o),
		.ext_sclk_o(ext_sclk), .ext_fs_o(ext_fs), .cap_o(cap),
		.nbits_o(nbits), .fe_cnt_o(fe_cnt), .fe_pos_o(fe_pos),
		.fs_cnt_o(fs_cnt));

	always #50 clock_i = ~clock_i;

	// Verdict and end of run
	task automatic print_verdict();
		if (err_total == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Compare and report
	task automatic chk(input string nm, input logic [159:0] seen, exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Left-justified word, fill bits zero
	function automatic logic [31:0] wd(input wl_sel_t wl, input sample_t x,
		input logic rd);
		if (rd || wl == 2'b00 || wl == 2'b11)
			return {x[23:8], 16'h0000};
		return {x[23:1], 9'h000};
	endfunction

	// Wait for a serial clock level, counting clocks
	task automatic wlev(input logic v, output int c);
		c = 0;
		while (sclk_o !== v && c < 100)
		begin
			@(negedge clock_i);
			c++;
		end
	endtask

	// One whole frame with its expected bit stream
	task automatic frame(input logic ms, input wl_sel_t wl,
		input logic [3:0] dv, input logic dm, ap, rd);
		logic [159:0] exp;
		sample_t      ws[5];
		int           nb, wb, n, per;
		ws = '{a_i_i, a_q_i, b_i_i, b_q_i, rd ? {read_data_i, 8'h00} : 24'h0};
		wb = (wl == 2'b01) ? 24 : (wl == 2'b10) ? 32 : 16;
		exp = '0;
		nb = 0;
		for (int k = 0; k < 5; k++)
			if (k < 2 || (k < 4 && dm) || (k == 4 && (ap || rd)))
			begin
				exp = (exp << wb) | 160'(wd(wl, ws[k], k == 4) >> (32 - wb));
				nb += wb;
			end
		@(posedge clock_i);
		bus_master_sel_i <= ms;
		word_length_sel_i <= wl;
		serial_clock_divider_i <= dv;
		append_i <= ap;
		diversity_mode_i <= dm;
		serial_cmd_in_i <= !ms;
		ncyc <= 8'(nb + 2);
		clr <= 1'b1;
		repeat (4) @(posedge clock_i);
		clr <= 1'b0;
		sample_valid_i <= 1'b1;
		read_req_i <= rd;
		@(posedge clock_i);
		sample_valid_i <= 1'b0;
		read_req_i <= 1'b0;
		start <= !ms;
		@(posedge clock_i);
		start <= 1'b0;
		if (ms)
		begin
			wlev(1'b0, n);
			wlev(1'b1, n);
			wlev(1'b0, n);
			per = n;
			wlev(1'b1, n);
			per += n;
			chk("period", 160'(per), 160'(2 * ((dv == 0) ? 1 : dv)));
		end
		n = 0;
		while (fe_cnt !== 8'h01 && n < 3000)
		begin
			@(negedge clock_i);
			n++;
		end
		repeat (40) @(negedge clock_i);
		chk("data", cap, exp);
		chk("bits", 160'(nbits), 160'(nb));
		chk("fe_pos", 160'(fe_pos), 160'(nb));
		chk("fe_cnt", 160'(fe_cnt), 160'h1);
		chk("data_oe", 160'(serial_data_oe_o), 160'h0);
		chk("sclk_oe", 160'(sclk_oe_o), 160'(ms));
		chk("fs_oe", 160'(frame_sync_oe_o), 160'(ms));
		chk("cmd_bit", 160'(cmd_bit_o), 160'(!ms));
		if (ms)
			chk("fs_len", 160'(fs_cnt), 160'h1);
	endtask

	// Main sequence
	initial
	begin
		clock_i = 1'b0;
		rst_b_i = 1'b0;
		{bus_master_sel_i, append_i, diversity_mode_i} = 3'h0;
		{sample_valid_i, read_req_i, serial_cmd_in_i, clr, start} = 5'h00;
		serial_clock_divider_i = 4'h2;
		word_length_sel_i = 2'b00;
		ncyc = 8'h00;
		a_i_i = 24'habcdef;
		a_q_i = 24'h123457;
		b_i_i = 24'h765433;
		b_q_i = 24'hfedcb9;
		read_data_i = 16'h0a5c;
		repeat (10) @(posedge clock_i);
		rst_b_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		frame(1'b1, 2'b00, 4'h2, 1'b0, 1'b0, 1'b0);
		frame(1'b1, 2'b01, 4'h0, 1'b1, 1'b0, 1'b0);
		frame(1'b1, 2'b10, 4'h3, 1'b0, 1'b1, 1'b0);
		frame(1'b1, 2'b00, 4'h1, 1'b0, 1'b0, 1'b1);
		frame(1'b1, 2'b11, 4'h2, 1'b0, 1'b0, 1'b0);
		frame(1'b0, 2'b00, 4'h5, 1'b0, 1'b1, 1'b1);
		print_verdict();
	end

	// Watchdog against a hang
	initial
	begin
		repeat (20000) @(posedge clock_i);
		err_total++;
		print_verdict();
	end
endmodule // serial_output_port_tb
